/* File: icq_dec_ascii.sv */
// unsigned binary to decimal ASCII, most significant digit first, no leading zeros
// assumes the consumer takes a character when charReady is high; one digit per few cycles
`timescale 1ns/1ps
`default_nettype none
module icq_dec_ascii (
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        start,
  input  wire logic [31:0] value,
  input  wire logic        charReady,
  output logic             charValid,
  output logic      [7:0]  charData,
  output logic             busy
);
  logic [31:0] rem;
  logic [3:0]  idx;
  logic [3:0]  digit;
  logic        started;
  logic [31:0] pow;

  always_comb begin
    case (idx)
      4'h9:    pow = 32'h3b9a_ca00;
      4'h8:    pow = 32'h05f5_e100;
      4'h7:    pow = 32'h0098_9680;
      4'h6:    pow = 32'h000f_4240;
      4'h5:    pow = 32'h0001_86a0;
      4'h4:    pow = 32'h0000_2710;
      4'h3:    pow = 32'h0000_03e8;
      4'h2:    pow = 32'h0000_0064;
      4'h1:    pow = 32'h0000_000a;
      default: pow = 32'h0000_0001;
    endcase
  end

  // repeated subtraction keeps this tiny; a ten-digit value needs at most ~100 cycles
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rem       <= 32'h0;
      idx       <= 4'h0;
      digit     <= 4'h0;
      started   <= 1'b0;
      busy      <= 1'b0;
      charValid <= 1'b0;
      charData  <= 8'h00;
    end else begin
      if (charValid && charReady) begin
        charValid <= 1'b0;
      end
      if (start) begin
        rem     <= value;
        idx     <= 4'h9;
        digit   <= 4'h0;
        started <= 1'b0;
        busy    <= 1'b1;
      end else if (busy && !charValid) begin
        if (rem >= pow) begin
          rem   <= rem - pow;
          digit <= digit + 4'h1;
        end else begin
          if (digit != 4'h0 || started || idx == 4'h0) begin
            charValid <= 1'b1;
            charData  <= icq_pkg::CHAR_ZERO | {4'h0, digit};
            started   <= 1'b1;
          end
          digit <= 4'h0;
          if (idx == 4'h0) begin
            busy <= 1'b0;
          end else begin
            idx <= idx - 4'h1;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: icq_far_model.sv */
// far side: reply byte sink with optional stalls, and the self-test engines
// assumes testReq is held until testDone
`timescale 1ns/1ps
`default_nettype none
module icq_far_model (
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire logic       txValid,
  input  wire logic [7:0] txData,
  input  wire logic [2:0] testReq,
  input  wire logic       slow,
  input  wire logic [7:0] resIn,
  output logic            txReady,
  output logic            testDone,
  output logic      [7:0] testResult
);
  logic [7:0] got [$];
  int         cnt = 0;

  always @(posedge mclk) begin
    if (txValid && txReady)
      got.push_back(txData);
    // random stalls check that a byte is held until taken
    txReady <= resetn && (!slow || $urandom_range(1, 0) == 1);
  end

  always @(posedge mclk) begin
    // result lines carry junk outside the done pulse
    testResult <= ~resIn;
    testDone <= 1'b0;
    if (!resetn || testReq == 3'h0 || testDone) begin
      cnt <= 0;
    end else if (cnt == 5) begin
      testDone <= 1'b1;
      testResult <= resIn;
      cnt <= 6;
    end else if (cnt < 5) begin
      cnt <= cnt + 1;
    end
  end
endmodule
`default_nettype wire

/* File: icq_interp.sv */
// command interpreter: calibration store, mass lock and error-byte queries
// assumes a parser delivering one decoded command per cmdValid pulse, a byte transmitter
// with valid/ready, and self-test engines on the same clock answering with testDone
`timescale 1ns/1ps
`default_nettype none
module icq_interp #(
  parameter int MASS_MAX_AMU = 300
) (
  input  wire logic        mclk,
  input  wire logic        resetn,
  // decoded command
  input  wire logic        cmdValid,
  input  wire logic [3:0]  cmdCode,
  input  wire logic        cmdHasParam,
  input  wire logic        cmdIsQuery,
  input  wire logic        cmdIsDefault,
  input  wire logic [31:0] cmdValue,
  output logic             cmdBusy,
  // response bytes
  output logic             txValid,
  output logic      [7:0]  txData,
  input  wire logic        txReady,
  // error sources
  input  wire logic        emPresentPin,
  input  wire logic [7:0]  linkErrSet,
  input  wire logic [7:0]  emErrSet,
  input  wire logic [7:0]  filErrSet,
  input  wire logic        filEmissionOk,
  // self tests: 0 electrometer, 1 supply, 2 filter
  output logic      [2:0]  testReq,
  input  wire logic        testDone,
  input  wire logic [7:0]  testResult,
  output logic             detRestore,
  // mass filter and summary status byte
  output logic             filterOn,
  output logic      [16:0] filterMass,
  output logic             filterStabilise,
  output logic      [7:0]  statusByte
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_TEST, ST_NV_WAIT, ST_NUM, ST_LF, ST_CR, ST_DONE
  } icq_state_t;

  localparam logic [31:0] MASS_MAX = 32'(MASS_MAX_AMU) * icq_pkg::VALUE_SCALE;

  icq_state_t  state;
  logic [2:0]  emSync;
  logic        emPresent;
  logic [7:0]  linkErr;
  logic [7:0]  detErr;
  logic [7:0]  filErr;
  logic [7:0]  emErr;
  logic [7:0]  supErr;
  logic [7:0]  fltErr;
  logic [3:0]  curCmd;
  logic        withCr;
  logic [1:0]  testIdx;

  logic        nvWe;
  logic [1:0]  nvAddr;
  logic [31:0] nvRdata;
  logic        encStart;
  logic [31:0] encValue;
  logic        encValid;
  logic [7:0]  encChar;
  logic        encBusy;

  // command classification
  logic        isStore;
  logic        isErrQuery;
  logic        badCmd;
  logic        badParam;
  logic [31:0] storeMax;
  logic [1:0]  storeSlot;
  logic [39:0] massProd;
  logic [39:0] massQ;
  logic        accept;

  assign accept = cmdValid && state == ST_IDLE;

  always_comb begin
    isStore   = cmdCode == icq_pkg::CMD_MULT_VOLT || cmdCode == icq_pkg::CMD_PART_SENS
             || cmdCode == icq_pkg::CMD_TOTAL_SENS;
    isErrQuery = cmdCode >= icq_pkg::CMD_LINK_ERR && cmdCode <= icq_pkg::CMD_FILTER;
    storeMax  = icq_pkg::MULT_VOLT_MAX;
    storeSlot = icq_pkg::SLOT_MULT_VOLT;
    if (cmdCode == icq_pkg::CMD_PART_SENS) begin
      storeMax  = icq_pkg::PART_SENS_MAX;
      storeSlot = icq_pkg::SLOT_PART_SENS;
    end else if (cmdCode == icq_pkg::CMD_TOTAL_SENS) begin
      storeMax  = icq_pkg::TOTAL_SENS_MAX;
      storeSlot = icq_pkg::SLOT_TOTAL_SENS;
    end
    badCmd   = 1'b0;
    badParam = 1'b0;
    if (cmdCode == icq_pkg::CMD_MULT_VOLT && !emPresent) begin
      badCmd = 1'b1;
    end else if (isStore) begin
      if (!cmdHasParam || cmdIsDefault) begin
        badParam = 1'b1;
      end else if (!cmdIsQuery && cmdValue > storeMax) begin
        badParam = 1'b1;
      end
    end else if (cmdCode == icq_pkg::CMD_MASS_LOCK) begin
      if (!cmdHasParam || cmdIsQuery || cmdIsDefault) begin
        badParam = 1'b1;
      end else if (cmdValue != 32'h0 && (cmdValue < icq_pkg::MASS_MIN || cmdValue > MASS_MAX)) begin
        badParam = 1'b1;
      end
    end else if (isErrQuery) begin
      if (!cmdHasParam || !cmdIsQuery) begin
        badParam = 1'b1;
      end
    end else begin
      badCmd = 1'b1;
    end
  end

  // round to the nearest 1/256 amu step
  assign massProd = {8'h00, cmdValue} * 40'(icq_pkg::MASS_STEPS_PER_AMU);
  assign massQ    = (massProd + {9'h000, icq_pkg::VALUE_SCALE[31:1]}) / {8'h00, icq_pkg::VALUE_SCALE};

  // multiplier strap crosses in through three stages
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      emSync    <= 3'b000;
      emPresent <= 1'b0;
    end else begin
      emSync <= {emSync[1:0], emPresentPin};
      if (emSync[1] == emSync[2]) begin
        emPresent <= emSync[2];
      end
    end
  end

  icq_nvmem u_nvmem (
    .mclk  (mclk),
    .we    (nvWe),
    .addr  (nvAddr),
    .wdata (cmdValue),
    .rdata (nvRdata)
  );

  // sensitivities and voltage go to the store only; nothing else reads them
  assign nvWe   = accept && isStore && !badCmd && !badParam && !cmdIsQuery;
  assign nvAddr = storeSlot;

  icq_dec_ascii u_dec (
    .mclk      (mclk),
    .resetn    (resetn),
    .start     (encStart),
    .value     (encValue),
    .charReady (!txValid),
    .charValid (encValid),
    .charData  (encChar),
    .busy      (encBusy)
  );

  // sequencer
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state      <= ST_IDLE;
      curCmd     <= icq_pkg::CMD_MULT_VOLT;
      withCr     <= 1'b1;
      testIdx    <= 2'h0;
      testReq    <= 3'b000;
      detRestore <= 1'b0;
      encStart   <= 1'b0;
      encValue   <= 32'h0;
      cmdBusy    <= 1'b0;
    end else begin
      encStart   <= 1'b0;
      detRestore <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (accept && !badCmd && !badParam) begin
            curCmd <= cmdCode;
            withCr <= cmdCode != icq_pkg::CMD_FILAMENT;
            if (isStore && cmdIsQuery) begin
              state   <= ST_NV_WAIT;
              cmdBusy <= 1'b1;
            end else if (cmdCode == icq_pkg::CMD_ELECTROM || cmdCode == icq_pkg::CMD_SUPPLY
                         || cmdCode == icq_pkg::CMD_FILTER) begin
              state   <= ST_TEST;
              cmdBusy <= 1'b1;
              testIdx <= cmdCode == icq_pkg::CMD_ELECTROM ? 2'(icq_pkg::TEST_DET)
                       : cmdCode == icq_pkg::CMD_SUPPLY ? 2'(icq_pkg::TEST_SUPPLY) : 2'(icq_pkg::TEST_FILTER);
              testReq <= cmdCode == icq_pkg::CMD_ELECTROM ? 3'b001
                       : cmdCode == icq_pkg::CMD_SUPPLY ? 3'b010 : 3'b100;
            end else if (isErrQuery) begin
              state    <= ST_NUM;
              cmdBusy  <= 1'b1;
              encStart <= 1'b1;
              if (cmdCode == icq_pkg::CMD_LINK_ERR) begin
                encValue <= {24'h0, linkErr};
              end else if (cmdCode == icq_pkg::CMD_FILAMENT) begin
                encValue <= {24'h0, filErr};
              end else begin
                encValue <= {24'h0, emErr | {!emPresent, 7'h00}};
              end
            end
          end
        end
        ST_TEST: begin
          if (testDone) begin
            testReq  <= 3'b000;
            encStart <= 1'b1;
            encValue <= {24'h0, testResult};
            state    <= ST_NUM;
            if (testIdx == 2'(icq_pkg::TEST_DET)) begin
              detRestore <= 1'b1;
            end
          end
        end
        ST_NV_WAIT: begin
          encStart <= 1'b1;
          encValue <= nvRdata;
          state    <= ST_NUM;
        end
        ST_NUM: begin
          if (!encStart && !encBusy && !encValid && !txValid) begin
            state <= ST_LF;
          end
        end
        ST_LF: begin
          if (!txValid) begin
            state <= withCr ? ST_CR : ST_DONE;
          end
        end
        ST_CR: begin
          if (!txValid) begin
            state <= ST_DONE;
          end
        end
        default: begin
          state   <= ST_IDLE;
          cmdBusy <= 1'b0;
        end
      endcase
    end
  end

  // transmit holding register
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      txValid <= 1'b0;
      txData  <= icq_pkg::BYTE_RESET;
    end else begin
      if (txValid && txReady) begin
        txValid <= 1'b0;
      end else if (!txValid) begin
        if (encValid) begin
          txValid <= 1'b1;
          txData  <= encChar;
        end else if (state == ST_LF) begin
          txValid <= 1'b1;
          txData  <= icq_pkg::CHAR_LF;
        end else if (state == ST_CR) begin
          txValid <= 1'b1;
          txData  <= icq_pkg::CHAR_CR;
        end
      end
    end
  end

  // error bytes; a set arriving with a clear is kept
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      linkErr <= icq_pkg::BYTE_RESET;
      emErr   <= icq_pkg::BYTE_RESET;
      filErr  <= icq_pkg::BYTE_RESET;
      detErr  <= icq_pkg::BYTE_RESET;
      supErr  <= icq_pkg::BYTE_RESET;
      fltErr  <= icq_pkg::BYTE_RESET;
    end else begin
      if (state == ST_DONE && curCmd == icq_pkg::CMD_LINK_ERR) begin
        linkErr <= linkErrSet;
      end else begin
        linkErr <= linkErr | linkErrSet;
      end
      if (accept && badCmd) begin
        linkErr[icq_pkg::LINK_BAD_CMD] <= 1'b1;
      end
      if (accept && badParam) begin
        linkErr[icq_pkg::LINK_BAD_PARAM] <= 1'b1;
      end
      if (state == ST_DONE && curCmd == icq_pkg::CMD_MULT_ERR) begin
        emErr <= emErrSet;
      end else begin
        emErr <= emErr | emErrSet;
      end
      // only the protection monitor touches this byte
      if (filErrSet != 8'h00) begin
        filErr <= filErr | filErrSet;
      end else if (filEmissionOk) begin
        filErr <= icq_pkg::BYTE_RESET;
      end
      if (state == ST_TEST && testDone) begin
        if (testIdx == 2'(icq_pkg::TEST_DET)) begin
          detErr <= testResult;
        end else if (testIdx == 2'(icq_pkg::TEST_SUPPLY)) begin
          supErr <= testResult;
        end else begin
          fltErr <= testResult;
        end
      end
    end
  end

  // summary status byte
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      statusByte <= icq_pkg::BYTE_RESET;
    end else begin
      statusByte                       <= 8'h00;
      statusByte[icq_pkg::ST_LINK]     <= linkErr != 8'h00;
      statusByte[icq_pkg::ST_MULT]     <= emErr != 8'h00;
      statusByte[icq_pkg::ST_DETECTOR] <= detErr != 8'h00;
      statusByte[icq_pkg::ST_SUPPLY]   <= supErr != 8'h00;
      statusByte[icq_pkg::ST_FILTER]   <= fltErr != 8'h00;
    end
  end

  // mass filter control; no ion current measurement is started here
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      filterOn        <= 1'b0;
      filterMass      <= 17'h0;
      filterStabilise <= 1'b0;
    end else if (cmdValid) begin
      filterStabilise <= 1'b0;
      if (accept && cmdCode == icq_pkg::CMD_MASS_LOCK && !badParam) begin
        if (cmdValue == 32'h0) begin
          filterOn   <= 1'b0;
          filterMass <= 17'h0;
        end else begin
          filterOn        <= 1'b1;
          filterMass      <= massQ[16:0];
          filterStabilise <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: icq_interp_chk.sv */
// concurrent checks on the command interpreter ports
// assumes one idle cycle between queries and no error sets while a reply is sent
`timescale 1ns/1ps
`default_nettype none
module icq_interp_chk #(
  parameter int MASS_MAX_AMU = 300
) (
  input wire logic        mclk,
  input wire logic        resetn,
  input wire logic        cmdValid,
  input wire logic [3:0]  cmdCode,
  input wire logic        cmdHasParam,
  input wire logic        cmdIsQuery,
  input wire logic        cmdIsDefault,
  input wire logic [31:0] cmdValue,
  input wire logic        cmdBusy,
  input wire logic        txValid,
  input wire logic [7:0]  txData,
  input wire logic        txReady,
  input wire logic [2:0]  testReq,
  input wire logic        testDone,
  input wire logic [7:0]  testResult,
  input wire logic        detRestore,
  input wire logic        filterOn,
  input wire logic [16:0] filterMass,
  input wire logic        filterStabilise,
  input wire logic [7:0]  statusByte
);
  logic        taken;
  logic        busyWas;
  logic        mlCmd;
  logic        txEnd;
  logic [3:0]  lastCode;
  logic [16:0] massExp;

  default clocking dcb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  // a take also needs the idle cycle after busy, which the bench keeps
  assign taken = cmdValid && !cmdBusy && !txValid && !busyWas;
  assign mlCmd = taken && cmdCode == icq_pkg::CMD_MASS_LOCK && cmdHasParam && !cmdIsQuery && !cmdIsDefault;
  assign massExp = 17'((40'(cmdValue) * 40'h100 + 40'h1388) / 40'h2710);
  assign txEnd = txValid && txReady;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      busyWas <= 1'b0;
    end else begin
      busyWas <= cmdBusy;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      lastCode <= 4'hf;
    end else if (taken) begin
      lastCode <= cmdCode;
    end
  end

  a_mass_centre: assert property (mlCmd && cmdValue >= icq_pkg::MASS_MIN
    && cmdValue <= 32'(MASS_MAX_AMU) * icq_pkg::VALUE_SCALE
    |=> filterOn && filterStabilise && filterMass == $past(massExp)) else $error("mass lock setting wrong");
  a_mass_off: assert property (mlCmd && cmdValue == 32'h0 |=> !filterOn) else $error("filter not off");
  a_stab_stop: assert property (cmdValid && cmdCode != icq_pkg::CMD_MASS_LOCK |=> !filterStabilise)
    else $error("stabilise kept");
  a_test_start: assert property (taken && cmdHasParam && cmdIsQuery && cmdCode inside {4'h5, 4'h8, 4'h9}
    |=> testReq == {$past(cmdCode) == 4'h9, $past(cmdCode) == 4'h8, $past(cmdCode) == 4'h5})
    else $error("wrong self test");
  a_test_hold: assert property (testReq != 3'h0 && !testDone |=> $stable(testReq)) else $error("test dropped");
  a_det_restore: assert property (testReq[0] && testDone |=> detRestore && testReq == 3'h0)
    else $error("detector not restored");
  a_status_test: assert property (testDone && testReq != 3'h0
    |-> ##2 ({statusByte[4], statusByte[6], statusByte[5]} & $past(testReq, 2))
    == (($past(testResult, 2) != 8'h00) ? $past(testReq, 2) : 3'h0)) else $error("status after test wrong");
  a_no_param: assert property (taken && cmdCode inside {[4'h3 : 4'h9]} && !cmdHasParam
    |=> testReq == 3'h0 ##[0:3] statusByte[0]) else $error("bare command not refused");
  a_link_clear: assert property (lastCode == icq_pkg::CMD_LINK_ERR && txEnd && txData == icq_pkg::CHAR_CR
    |-> ##[1:4] !statusByte[0]) else $error("link status kept");
  a_mult_clear: assert property (lastCode == icq_pkg::CMD_MULT_ERR && txEnd && txData == icq_pkg::CHAR_CR
    |-> ##[1:4] !statusByte[3]) else $error("multiplier status kept");
  a_fil_lf: assert property (lastCode == icq_pkg::CMD_FILAMENT && txEnd && txData == icq_pkg::CHAR_LF
    |=> !(txValid && txData == icq_pkg::CHAR_CR) [*4]) else $error("filament reply has CR");
endmodule

bind icq_interp icq_interp_chk #(.MASS_MAX_AMU(MASS_MAX_AMU)) chk (.mclk(mclk), .resetn(resetn),
  .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdHasParam(cmdHasParam), .cmdIsQuery(cmdIsQuery),
  .cmdIsDefault(cmdIsDefault), .cmdValue(cmdValue), .cmdBusy(cmdBusy), .txValid(txValid), .txData(txData),
  .txReady(txReady), .testReq(testReq), .testDone(testDone), .testResult(testResult), .detRestore(detRestore),
  .filterOn(filterOn), .filterMass(filterMass), .filterStabilise(filterStabilise), .statusByte(statusByte));
`default_nettype wire

/* File: icq_nvmem.sv */
// small calibration store: four 32-bit words, registered read data
// assumes one access per cycle; contents survive reset as a real non-volatile store would
`timescale 1ns/1ps
`default_nettype none
module icq_nvmem (
  input  wire logic        mclk,
  input  wire logic        we,
  input  wire logic [1:0]  addr,
  input  wire logic [31:0] wdata,
  output logic      [31:0] rdata
);
  logic [31:0] mem [0:3];

  always_ff @(posedge mclk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule
`default_nettype wire

/* File: icq_pkg.sv */
// command codes, error-byte layout and numeric limits for the command interpreter
// assumes an upstream parser that turns received text into a code, flags and a scaled value
package icq_pkg;

  // command codes as delivered by the parser
  localparam logic [3:0] CMD_MULT_VOLT   = 4'h0;
  localparam logic [3:0] CMD_PART_SENS   = 4'h1;
  localparam logic [3:0] CMD_TOTAL_SENS  = 4'h2;
  localparam logic [3:0] CMD_MASS_LOCK   = 4'h3;
  localparam logic [3:0] CMD_LINK_ERR    = 4'h4;
  localparam logic [3:0] CMD_ELECTROM    = 4'h5;
  localparam logic [3:0] CMD_FILAMENT    = 4'h6;
  localparam logic [3:0] CMD_MULT_ERR    = 4'h7;
  localparam logic [3:0] CMD_SUPPLY      = 4'h8;
  localparam logic [3:0] CMD_FILTER      = 4'h9;

  // parameter values arrive in units of 1/10000
  localparam logic [31:0] VALUE_SCALE    = 32'h0000_2710;
  localparam logic [31:0] MULT_VOLT_MAX  = 32'h017b_f0a0;  // 2489.9744
  localparam logic [31:0] PART_SENS_MAX  = 32'h0001_86a0;  // 10.0000
  localparam logic [31:0] TOTAL_SENS_MAX = 32'h000f_4240;  // 100.0000
  localparam logic [31:0] MASS_MIN       = 32'h0000_0028;  // 0.0040
  localparam int          MASS_STEPS_PER_AMU = 256;

  // non-volatile slots
  localparam logic [1:0] SLOT_MULT_VOLT  = 2'h0;
  localparam logic [1:0] SLOT_PART_SENS  = 2'h1;
  localparam logic [1:0] SLOT_TOTAL_SENS = 2'h2;

  // error byte bits raised by the interpreter itself: link bad command and bad parameter, multiplier absent
  localparam int LINK_BAD_CMD   = 1;
  localparam int LINK_BAD_PARAM = 2;
  localparam int EM_ABSENT_BIT  = 7;

  // summary status byte bits
  localparam int ST_LINK     = 0;
  localparam int ST_MULT     = 3;
  localparam int ST_FILTER   = 4;
  localparam int ST_DETECTOR = 5;
  localparam int ST_SUPPLY   = 6;

  // self-test request index
  localparam int TEST_DET    = 0;
  localparam int TEST_SUPPLY = 1;
  localparam int TEST_FILTER = 2;

  localparam logic [7:0] CHAR_LF    = 8'h0a;
  localparam logic [7:0] CHAR_CR    = 8'h0d;
  localparam logic [7:0] CHAR_ZERO  = 8'h30;
  localparam logic [7:0] BYTE_RESET = 8'h00;

endpackage

/* File: testbench.sv */
// self-checking bench for the command interpreter
// assumes the far model answers tests after a few cycles and collects reply bytes
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int MAXAMU = 300;
  logic        mclk, resetn, cmdValid, cmdHasParam, cmdIsQuery, cmdIsDefault, cmdBusy;
  logic        txValid, txReady, emPresentPin, filEmissionOk, testDone, detRestore;
  logic        filterOn, filterStabilise, slow;
  logic [3:0]  cmdCode;
  logic [31:0] cmdValue;
  logic [7:0]  txData, linkErrSet, emErrSet, filErrSet, testResult, statusByte, resIn;
  logic [2:0]  testReq;
  logic [16:0] filterMass;
  int          mismatches = 0;
  int          cmpCount = 0;

  icq_interp #(.MASS_MAX_AMU(MAXAMU)) uut (.mclk(mclk), .resetn(resetn), .cmdValid(cmdValid),
    .cmdCode(cmdCode), .cmdHasParam(cmdHasParam), .cmdIsQuery(cmdIsQuery), .cmdIsDefault(cmdIsDefault),
    .cmdValue(cmdValue), .cmdBusy(cmdBusy), .txValid(txValid), .txData(txData), .txReady(txReady),
    .emPresentPin(emPresentPin), .linkErrSet(linkErrSet), .emErrSet(emErrSet), .filErrSet(filErrSet),
    .filEmissionOk(filEmissionOk), .testReq(testReq), .testDone(testDone), .testResult(testResult),
    .detRestore(detRestore), .filterOn(filterOn), .filterMass(filterMass), .filterStabilise(filterStabilise),
    .statusByte(statusByte));
  icq_far_model far (.mclk(mclk), .resetn(resetn), .txValid(txValid), .txData(txData), .testReq(testReq),
    .slow(slow), .resIn(resIn), .txReady(txReady), .testDone(testDone), .testResult(testResult));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmpCount, mismatches);
    if (mismatches == 0 && cmpCount > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  function automatic logic [16:0] mround(input logic [31:0] v);
    return 17'((64'(v) * 64'h100 + 64'h1388) / 64'h2710);
  endfunction

  task automatic send(input logic [3:0] c, input logic p, input logic q, input logic d, input logic [31:0] v);
    @(posedge mclk);
    cmdValid <= 1'b1;
    cmdCode <= c;
    cmdHasParam <= p;
    cmdIsQuery <= q;
    cmdIsDefault <= d;
    cmdValue <= v;
    @(posedge mclk);
    cmdValid <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask

  task automatic raise(input logic [7:0] l, input logic [7:0] e, input logic [7:0] f, input logic ok);
    @(posedge mclk);
    linkErrSet <= l;
    emErrSet <= e;
    filErrSet <= f;
    filEmissionOk <= ok;
    @(posedge mclk);
    linkErrSet <= 8'h00;
    emErrSet <= 8'h00;
    filErrSet <= 8'h00;
    filEmissionOk <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask

  // query and compare the whole reply; the extra edge is the idle gap before the next query
  task automatic ask(input logic [3:0] c, input logic [31:0] v, input logic lfOnly);
    string e;
    int    n;
    e = lfOnly ? $sformatf("%0d\n", v) : $sformatf("%0d\n\r", v);
    far.got.delete();
    send(c, 1'b1, 1'b1, 1'b0, 32'h0);
    n = 0;
    while ((cmdBusy !== 1'b0 || far.got.size() < e.len()) && n < 2000) begin
      @(posedge mclk);
      n++;
    end
    if (n == 2000) begin
      mismatches++;
      wrap_up();
    end
    @(posedge mclk);
    check("reply length", far.got.size(), e.len());
    foreach (far.got[i])
      if (i < e.len()) check("reply byte", far.got[i], e[i]);
  endtask

  initial begin
    logic [31:0] v;
    logic [7:0]  r;
    logic [3:0]  c;
    int          b;
    {resetn, cmdValid, cmdHasParam, cmdIsQuery, cmdIsDefault, filEmissionOk, slow} = 7'h00;
    {linkErrSet, emErrSet, filErrSet, resIn} = 32'h0;
    cmdCode = 4'h0;
    cmdValue = 32'h0;
    emPresentPin = 1'b1;
    v = $urandom(17);
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    repeat (5) @(posedge mclk);
    raise(8'h81, 8'h00, 8'h00, 1'b0);
    check("link status", statusByte[icq_pkg::ST_LINK], 1'b1);
    ask(icq_pkg::CMD_LINK_ERR, 32'h81, 1'b0);
    check("link status clear", statusByte[icq_pkg::ST_LINK], 1'b0);
    ask(icq_pkg::CMD_LINK_ERR, 32'h0, 1'b0);
    send(icq_pkg::CMD_SUPPLY, 1'b0, 1'b0, 1'b0, 32'h0);
    send(4'hc, 1'b1, 1'b1, 1'b0, 32'h0);
    send(icq_pkg::CMD_MULT_VOLT, 1'b0, 1'b0, 1'b0, 32'h0);
    ask(icq_pkg::CMD_LINK_ERR, 32'h6, 1'b0);
    for (int j = 0; j < 3; j++) begin
      v = (j == 0) ? icq_pkg::PART_SENS_MAX : $urandom_range(100000, 0);
      send(icq_pkg::CMD_PART_SENS, 1'b1, 1'b0, 1'b0, v);
      send(icq_pkg::CMD_PART_SENS, 1'b1, 1'b0, 1'b0, icq_pkg::PART_SENS_MAX + 1);
      send(icq_pkg::CMD_PART_SENS, 1'b1, 1'b0, 1'b1, 32'h0);
      ask(icq_pkg::CMD_PART_SENS, v, 1'b0);
      v = (j == 0) ? icq_pkg::TOTAL_SENS_MAX : $urandom_range(1000000, 0);
      send(icq_pkg::CMD_TOTAL_SENS, 1'b1, 1'b0, 1'b0, v);
      send(icq_pkg::CMD_TOTAL_SENS, 1'b1, 1'b0, 1'b0, icq_pkg::TOTAL_SENS_MAX + 1);
      send(icq_pkg::CMD_TOTAL_SENS, 1'b1, 1'b0, 1'b1, 32'h0);
      ask(icq_pkg::CMD_TOTAL_SENS, v, 1'b0);
      ask(icq_pkg::CMD_LINK_ERR, 32'h4, 1'b0);
    end
    for (int j = 0; j < 6; j++) begin
      v = (j == 0) ? icq_pkg::MASS_MIN : (j == 1) ? MAXAMU * 10000 : $urandom_range(MAXAMU * 10000, 40);
      send(icq_pkg::CMD_MASS_LOCK, 1'b1, 1'b0, 1'b0, v);
      check("filter mass", filterMass, mround(v));
      check("filter on", {filterOn, filterStabilise}, 2'h3);
    end
    // any other command ends stabilisation but leaves the filter parked
    ask(icq_pkg::CMD_FILAMENT, 32'h0, 1'b1);
    check("stabilise stop", {filterOn, filterStabilise}, 2'h2);
    send(icq_pkg::CMD_MASS_LOCK, 1'b1, 1'b0, 1'b0, 32'h0);
    check("filter off", filterOn, 1'b0);
    send(icq_pkg::CMD_MASS_LOCK, 1'b0, 1'b0, 1'b0, 32'h0);
    send(icq_pkg::CMD_MASS_LOCK, 1'b1, 1'b0, 1'b0, icq_pkg::MASS_MIN - 1);
    send(icq_pkg::CMD_MASS_LOCK, 1'b1, 1'b0, 1'b0, MAXAMU * 10000 + 1);
    ask(icq_pkg::CMD_LINK_ERR, 32'h4, 1'b0);
    slow <= 1'b1;
    for (int j = 0; j < 6; j++) begin
      r = (j < 3) ? 8'h00 : 8'($urandom_range(255, 1));
      c = (j % 3 == 0) ? icq_pkg::CMD_ELECTROM : (j % 3 == 1) ? icq_pkg::CMD_SUPPLY : icq_pkg::CMD_FILTER;
      b = (j % 3 == 0) ? icq_pkg::ST_DETECTOR : (j % 3 == 1) ? icq_pkg::ST_SUPPLY : icq_pkg::ST_FILTER;
      resIn <= r;
      ask(c, r, 1'b0);
      check("test status", statusByte[b], r != 8'h00);
    end
    raise(8'h00, 8'h05, 8'h00, 1'b0);
    ask(icq_pkg::CMD_MULT_ERR, 32'h5, 1'b0);
    check("mult status", statusByte[icq_pkg::ST_MULT], 1'b0);
    emPresentPin <= 1'b0;
    repeat (5) @(posedge mclk);
    ask(icq_pkg::CMD_MULT_ERR, 32'h80, 1'b0);
    send(icq_pkg::CMD_MULT_VOLT, 1'b1, 1'b0, 1'b0, 32'h3e8);
    ask(icq_pkg::CMD_LINK_ERR, 32'h2, 1'b0);
    emPresentPin <= 1'b1;
    repeat (5) @(posedge mclk);
    ask(icq_pkg::CMD_MULT_ERR, 32'h0, 1'b0);
    raise(8'h00, 8'h00, 8'h0c, 1'b0);
    ask(icq_pkg::CMD_FILAMENT, 32'hc, 1'b1);
    ask(icq_pkg::CMD_FILAMENT, 32'hc, 1'b1);
    raise(8'h00, 8'h00, 8'h00, 1'b1);
    ask(icq_pkg::CMD_FILAMENT, 32'h0, 1'b1);
    wrap_up();
  end
endmodule
`default_nettype wire
